/* File: hw/burst_ctrl_consts.svh */
// offsets, field positions, reset values and timing counts of the control block
// assumes one clock (the receive IF clock) at 25 MHz and an APB register port
//
// Behaviour
// RULE1 - sample format chosen by config bit three
// RULE2 - samples latched every IF clock; source keeps rate
// RULE3 - direct IF: quadrature input held at zero
// RULE4 - manual strobe edge makes baseband pulse after sync
// RULE5 - dump transfer one cycle after baseband pulse
// RULE6 - source gives two IF cycles per strobe
// RULE7 - detect pulse only when manual detect enabled
// RULE8 - detect pin ORed with software detect bit
// RULE9 - demod transfer second baseband tick after detect
// RULE10 - abort pin ORed with software abort bit
// RULE11 - abort second baseband tick, counters cleared
// RULE12 - counters idle until preamble or manual detect
// RULE13 - internal baseband divider when manual sample off
// RULE14 - source runs IF clock at four chip rates
// RULE15 - oscillator enable ORed; low holds oscillator reset
// RULE16 - oscillator reset next cycle, registers kept
// RULE17 - source reloads frequency word after re-enable
// RULE18 - transmit enable rise starts preamble then data
// RULE19 - transmit pin ORed with power bit one
// RULE20 - transmit enable fall resets datapath next cycle
// RULE21 - source drops transmit enable after last symbol
// RULE22 - sources synchronised two stages, then edge compared
`ifndef BURST_CTRL_CONSTS_SVH
`define BURST_CTRL_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------
`define REG_CFG_IDX 8'h01
`define REG_DIV_IDX 8'h02
`define REG_DET_CTRL_IDX 8'h30
`define REG_DET_SW_IDX 8'h31
`define REG_ABORT_SW_IDX 8'h32
`define REG_PWR_IDX 8'h37
`define REG_STATUS_IDX 8'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_MANUAL_SAMPLE_BIT 0
`define CFG_OFFSET_BINARY_BIT 3
`define PWR_OSC_BIT 0
`define PWR_TX_BIT 1

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define CFG_RESET 8'h00
`define DIV_RESET 6'h02
`define PWR_RESET 2'h0
`define SYNC_STAGES 2
`define BB_TICKS_TO_ACT 2'h2
`define SIGN_FLIP 8'h80

`endif

/* File: hw/burst_ctrl_pkg.sv */
// types shared by the control block
// assumes nothing of its surroundings
package burst_ctrl_pkg;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_PREAMBLE,
        TX_DATA
    } txState_t;
endpackage

/* File: hw/burst_modem_ctrl.sv */
// input-side control of the burst modem: sample intake, manual strobes, enables
// assumes clk is the IF clock for receive and transmit, APB master on clk
//
// The address map and the APB slave port were decided locally.
`include "burst_ctrl_consts.svh"
module burst_modem_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sample inputs
    input wire logic [7:0] in_phase_sample_in,
    input wire logic [7:0] quadrature_sample_in,
    // manual strobes and enable pins
    input wire logic ext_baseband_sample_strobe,
    input wire logic ext_symbol_detect_strobe,
    input wire logic ext_burst_abort_strobe,
    input wire logic osc_enable_pin,
    input wire logic tx_enable_pin,
    // datapath events
    input wire logic preambleDetect,
    input wire logic preambleSent,
    // datapath controls
    output logic [7:0] iSample,
    output logic [7:0] qSample,
    output logic basebandPulse,
    output logic dumpTransfer,
    output logic detectPulse,
    output logic demodTransfer,
    output logic abortPulse,
    output logic countersActive,
    output logic oscReset,
    output logic txStart,
    output logic txPreamble,
    output logic txActive,
    output logic txDatapathReset
);
    logic [7:0] cfg_reg;
    logic [5:0] div_reg;
    logic detEnable_reg;
    logic detSw_reg;
    logic abortSw_reg;
    logic [1:0] pwr_reg;
    logic [5:0] divCnt_reg;
    logic [1:0] detCnt_reg;
    logic [1:0] abortCnt_reg;
    burst_ctrl_pkg::txState_t txState_reg;
    logic manualMode;
    logic offsetBinary;
    logic bbTick;
    logic divTick;
    logic [7:0] regIndex;
    logic bbLevel, bbRise;
    logic detLevel, detRise;
    logic abortLevel, abortRise;
    logic oscLevel;
    logic txLevel, txRise, txFall;
    logic apbWrite;

    assign manualMode = cfg_reg[`CFG_MANUAL_SAMPLE_BIT];
    assign offsetBinary = cfg_reg[`CFG_OFFSET_BINARY_BIT];
    assign regIndex = paddr[9:2];
    assign apbWrite = psel & penable & pwrite;

    // ----------------------------------------
    // control sources
    // ----------------------------------------
    edge_sync bbSync (.clk(clk), .reset(reset), .pinIn(ext_baseband_sample_strobe), .swBit(1'b0),
        .level(bbLevel), .rise(bbRise), .fall());
    edge_sync detSync (.clk(clk), .reset(reset), .pinIn(ext_symbol_detect_strobe), .swBit(detSw_reg),
        .level(detLevel), .rise(detRise), .fall());
    edge_sync abortSync (.clk(clk), .reset(reset), .pinIn(ext_burst_abort_strobe), .swBit(abortSw_reg),
        .level(abortLevel), .rise(abortRise), .fall());
    edge_sync oscSync (.clk(clk), .reset(reset), .pinIn(osc_enable_pin), .swBit(pwr_reg[`PWR_OSC_BIT]),
        .level(oscLevel), .rise(), .fall());
    edge_sync txSync (.clk(clk), .reset(reset), .pinIn(tx_enable_pin), .swBit(pwr_reg[`PWR_TX_BIT]),
        .level(txLevel), .rise(txRise), .fall(txFall));

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_reg <= `CFG_RESET;
            div_reg <= `DIV_RESET;
            detEnable_reg <= 1'b0;
            detSw_reg <= 1'b0;
            abortSw_reg <= 1'b0;
            pwr_reg <= `PWR_RESET;
        end else if (apbWrite) begin
            unique case (regIndex)
                `REG_CFG_IDX: cfg_reg <= pwdata[7:0];
                `REG_DIV_IDX: div_reg <= pwdata[5:0];
                `REG_DET_CTRL_IDX: detEnable_reg <= pwdata[0];
                `REG_DET_SW_IDX: detSw_reg <= pwdata[0];
                `REG_ABORT_SW_IDX: abortSw_reg <= pwdata[0];
                `REG_PWR_IDX: pwr_reg <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel & ~penable) begin
                unique case (regIndex)
                    `REG_CFG_IDX: prdata <= {24'h00_0000, cfg_reg};
                    `REG_DIV_IDX: prdata <= {26'h000_0000, div_reg};
                    `REG_DET_CTRL_IDX: prdata <= {31'h0000_0000, detEnable_reg};
                    `REG_DET_SW_IDX: prdata <= {31'h0000_0000, detSw_reg};
                    `REG_ABORT_SW_IDX: prdata <= {31'h0000_0000, abortSw_reg};
                    `REG_PWR_IDX: prdata <= {30'h0000_0000, pwr_reg};
                    `REG_STATUS_IDX: prdata <= {28'h000_0000, txPreamble, txActive, countersActive, ~oscReset};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // sample intake
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            iSample <= 8'h00;
            qSample <= 8'h00;
        end else begin
            // see RULE2, RULE1: outputs always two's complement
            iSample <= offsetBinary ? (in_phase_sample_in ^ `SIGN_FLIP) : in_phase_sample_in;
            qSample <= offsetBinary ? (quadrature_sample_in ^ `SIGN_FLIP) : quadrature_sample_in;
        end
    end

    // ----------------------------------------
    // baseband clock
    // ----------------------------------------
    assign divTick = (div_reg == 6'h00) || (divCnt_reg >= div_reg - 6'h01);
    assign bbTick = basebandPulse;

    always_ff @(posedge clk) begin
        if (reset) begin
            divCnt_reg <= 6'h00;
            basebandPulse <= 1'b0;
        end else if (manualMode) begin
            divCnt_reg <= 6'h00;
            basebandPulse <= bbRise; // see RULE4
        end else begin
            divCnt_reg <= divTick ? 6'h00 : divCnt_reg + 6'h01; // see RULE13
            basebandPulse <= divTick;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dumpTransfer <= 1'b0;
        end else begin
            dumpTransfer <= basebandPulse; // see RULE5
        end
    end

    // ----------------------------------------
    // manual detect
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            detectPulse <= 1'b0;
            detCnt_reg <= 2'h0;
            demodTransfer <= 1'b0;
        end else begin
            detectPulse <= detRise & detEnable_reg; // see RULE7, RULE8
            demodTransfer <= 1'b0;
            if (detRise & detEnable_reg) begin
                detCnt_reg <= `BB_TICKS_TO_ACT;
            end else if (bbTick && detCnt_reg != 2'h0) begin
                detCnt_reg <= detCnt_reg - 2'h1;
                demodTransfer <= (detCnt_reg == 2'h1); // see RULE9
            end
        end
    end

    // ----------------------------------------
    // burst abort and counters
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            abortCnt_reg <= 2'h0;
            abortPulse <= 1'b0;
        end else begin
            abortPulse <= 1'b0;
            if (abortRise) begin
                abortCnt_reg <= `BB_TICKS_TO_ACT; // see RULE10
            end else if (bbTick && abortCnt_reg != 2'h0) begin
                abortCnt_reg <= abortCnt_reg - 2'h1;
                abortPulse <= (abortCnt_reg == 2'h1); // see RULE11
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            countersActive <= 1'b0;
        end else if (abortPulse) begin
            countersActive <= 1'b0; // see RULE11
        end else if (preambleDetect | detectPulse) begin
            countersActive <= 1'b1; // see RULE12
        end
    end

    // ----------------------------------------
    // oscillator and transmitter enables
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            oscReset <= 1'b1;
        end else begin
            oscReset <= ~oscLevel; // see RULE15, RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            txState_reg <= burst_ctrl_pkg::TX_IDLE;
            txStart <= 1'b0;
            txDatapathReset <= 1'b0;
        end else begin
            txStart <= txRise; // see RULE19
            txDatapathReset <= txFall; // see RULE20
            if (txFall) begin
                txState_reg <= burst_ctrl_pkg::TX_IDLE;
            end else if (txRise) begin
                txState_reg <= burst_ctrl_pkg::TX_PREAMBLE; // see RULE18
            end else begin
                unique case (txState_reg)
                    burst_ctrl_pkg::TX_IDLE: ;
                    burst_ctrl_pkg::TX_PREAMBLE: begin
                        if (preambleSent) begin
                            txState_reg <= burst_ctrl_pkg::TX_DATA;
                        end
                    end
                    burst_ctrl_pkg::TX_DATA: ;
                    default: txState_reg <= burst_ctrl_pkg::TX_IDLE;
                endcase
            end
        end
    end

    assign txPreamble = (txState_reg == burst_ctrl_pkg::TX_PREAMBLE);
    assign txActive = (txState_reg != burst_ctrl_pkg::TX_IDLE);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence detectArmed;
        detRise && detEnable_reg;
    endsequence

    sample_format_a: assert property (##1 iSample == ($past(offsetBinary) ? ($past(in_phase_sample_in) ^ 8'h80)
        : $past(in_phase_sample_in))) else $error("sample format wrong"); // see RULE1
    manual_bb_a: assert property (manualMode && bbRise && !(apbWrite && regIndex == `REG_CFG_IDX)
        |=> basebandPulse) else $error("baseband pulse missing"); // see RULE4
    dump_follow_a: assert property (basebandPulse |=> dumpTransfer) else $error("dump transfer missing"); // see RULE5
    detect_gate_a: assert property (detectPulse |-> $past(detEnable_reg) && $past(detRise))
        else $error("detect without enable"); // see RULE7
    detect_fire_a: assert property (detectArmed |=> detectPulse) else $error("detect pulse missing"); // see RULE8
    demod_pair_a: assert property (demodTransfer |-> $past(bbTick) && detCnt_reg == 2'h0)
        else $error("demod transfer early"); // see RULE9
    abort_clear_a: assert property (abortPulse |=> !countersActive) else $error("counters not cleared"); // see RULE11
    osc_reset_a: assert property (!oscLevel |=> oscReset) else $error("oscillator not reset"); // see RULE16
    tx_start_a: assert property (txRise |=> txStart && txPreamble) else $error("transmit start missing"); // see RULE18
    tx_reset_a: assert property (txFall |=> txDatapathReset && !txActive)
        else $error("transmit reset missing"); // see RULE20
endmodule

/* File: hw/edge_sync.sv */
// one control source: pin synchronised, ORed with a register bit, edges found
// assumes the pin is asynchronous to clk and the bit is on clk
`include "burst_ctrl_consts.svh"
module edge_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sources
    input wire logic pinIn,
    input wire logic swBit,
    // results
    output logic level,
    output logic rise,
    output logic fall
);
    logic [`SYNC_STAGES-1:0] syncReg;
    logic prevReg;

    // ----------------------------------------
    // synchroniser and previous sample
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            syncReg <= '0;
            prevReg <= 1'b0;
        end else begin
            syncReg <= {syncReg[0], pinIn}; // see RULE22
            prevReg <= level;
        end
    end

    assign level = syncReg[`SYNC_STAGES-1] | swBit; // see RULE8
    assign rise = level & ~prevReg; // see RULE22
    assign fall = ~level & prevReg;
endmodule

/* File: verification/adc_strobe_model.sv */
// partner model: sample converters and a controller driving the strobe pins
// assumes its tasks are entered just after a rising clk edge
module adc_strobe_model (
    // clock
    input wire logic clk,
    // sample buses
    output logic [7:0] iOut,
    output logic [7:0] qOut,
    // strobe and enable pins
    output logic sampleStrobe,
    output logic detectStrobe,
    output logic abortStrobe,
    output logic oscEnable,
    output logic txEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] pins = 5'h00;
    assign sampleStrobe = pins[0];
    assign detectStrobe = pins[1];
    assign abortStrobe = pins[2];
    assign oscEnable = pins[3];
    assign txEnable = pins[4];
    initial begin
        iOut = 8'h00;
        qOut = 8'h00;
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    // each sample held two clk, quadrature held at arithmetic zero
    task automatic setSamples(input logic [7:0] i, input logic offsetFmt);
        iOut <= i;
        qOut <= offsetFmt ? 8'h80 : 8'h00;
        repeat (2) @(posedge clk);
    endtask
    // each level held six clk, so every half period spans several clk
    task automatic level(input int k, input logic v);
        pins[k] <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse(input int k);
        level(k, 1'b1);
        level(k, 1'b0);
    endtask
endmodule

/* File: verification/burst_modem_ctrl_tb.sv */
// self-checking bench of the burst modem input control block
// assumes the partner model drives the pins and this module is the apb master
`include "burst_ctrl_consts.svh"
module burst_modem_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, err, preambleDetect, preambleSent;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] iIn, qIn, iSample, qSample;
    logic smp, det, abt, oscEn, txEn, countersActive, oscReset, txPreamble, txActive;
    logic [6:0] ev;
    int errors = 0;
    int samples_checked = 0;
    int cnt[7] = '{default: 0};
    int snap[7];
    int n;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    adc_strobe_model PM (.clk(clk), .iOut(iIn), .qOut(qIn), .sampleStrobe(smp), .detectStrobe(det),
        .abortStrobe(abt), .oscEnable(oscEn), .txEnable(txEn));
    burst_modem_ctrl DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_phase_sample_in(iIn), .quadrature_sample_in(qIn), .ext_baseband_sample_strobe(smp),
        .ext_symbol_detect_strobe(det), .ext_burst_abort_strobe(abt), .osc_enable_pin(oscEn),
        .tx_enable_pin(txEn), .preambleDetect(preambleDetect), .preambleSent(preambleSent),
        .iSample(iSample), .qSample(qSample), .basebandPulse(ev[0]), .dumpTransfer(ev[1]),
        .detectPulse(ev[2]), .demodTransfer(ev[3]), .abortPulse(ev[4]), .countersActive(countersActive),
        .oscReset(oscReset), .txStart(ev[5]), .txPreamble(txPreamble), .txActive(txActive),
        .txDatapathReset(ev[6]));
    // ----------------------------------------
    // event counters and tasks
    // ----------------------------------------
    always @(posedge clk) begin
        for (int k = 0; k < 7; k++) begin
            if (ev[k] === 1'b1) cnt[k]++;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkEv(input int k, input int exp);
        chk(cnt[k] - snap[k], exp);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic waitBb(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (ev[0] !== 1'b1 && c < 64);
    endtask
    task automatic evt(input logic sent);
        preambleDetect <= ~sent;
        preambleSent <= sent;
        @(posedge clk);
        preambleDetect <= 1'b0;
        preambleSent <= 1'b0;
        idle(3);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        idle(5000);
        errors++;
        conclude();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, preambleDetect, preambleSent, reset} = 6'h01;
        paddr = 10'h000;
        pwdata = 32'h0;
        idle(4);
        reset <= 1'b0;
        @(posedge clk);
        chk(oscReset, 1);
        chk(countersActive, 0);
        apb(0, `REG_DIV_IDX, 0);
        chk(rd, 32'h2);
        apb(0, 8'h10, 0);
        chk({rd[30:0], err}, 32'h1);
        apb(1, `REG_DIV_IDX, 32'h3);
        waitBb(n);
        waitBb(n);
        waitBb(n);
        chk(n, 3);
        for (int f = 0; f < 2; f++) begin
            apb(1, `REG_CFG_IDX, {28'h0, f[0], 3'h1});
            PM.setSamples(f ? 8'h85 : 8'h3c, f[0]);
            chk(iSample, f ? 8'h05 : 8'h3c);
            chk(qSample, 8'h00);
        end
        snap = cnt;
        idle(8);
        chkEv(0, 0);
        PM.pulse(0);
        chkEv(0, 1);
        chkEv(1, 1);
        evt(1'b0);
        chk(countersActive, 1);
        snap = cnt;
        PM.pulse(2);
        PM.pulse(0);
        chkEv(4, 0);
        PM.pulse(0);
        chkEv(4, 1);
        PM.pulse(0);
        chk(countersActive, 0);
        PM.pulse(1);
        chkEv(2, 0);
        apb(1, `REG_DET_CTRL_IDX, 1);
        snap = cnt;
        PM.pulse(1);
        chkEv(2, 1);
        chk(countersActive, 1);
        PM.pulse(0);
        chkEv(3, 0);
        PM.pulse(0);
        chkEv(3, 1);
        apb(1, `REG_DET_SW_IDX, 1);
        idle(4);
        chkEv(2, 2);
        PM.pulse(1);
        chkEv(2, 2);
        apb(1, `REG_DET_SW_IDX, 0);
        apb(1, `REG_ABORT_SW_IDX, 1);
        PM.pulse(0);
        PM.pulse(0);
        chkEv(4, 1);
        apb(1, `REG_ABORT_SW_IDX, 0);
        PM.level(3, 1);
        chk(oscReset, 0);
        PM.level(3, 0);
        chk(oscReset, 1);
        apb(1, `REG_PWR_IDX, 1);
        idle(3);
        chk(oscReset, 0);
        apb(1, 8'h00, 32'h1);
        chk(err, 1);
        PM.level(3, 1);
        apb(1, `REG_PWR_IDX, 0);
        idle(3);
        chk(oscReset, 0);
        PM.level(3, 0);
        chk(oscReset, 1);
        apb(0, `REG_CFG_IDX, 0);
        chk(rd, 32'h9);
        snap = cnt;
        PM.level(4, 1);
        chkEv(5, 1);
        chk(txPreamble, 1);
        evt(1'b1);
        chk({txPreamble, txActive}, 32'h1);
        apb(0, `REG_STATUS_IDX, 0);
        chk(rd, 32'h4);
        PM.level(4, 0);
        chkEv(6, 1);
        chk(txActive, 0);
        apb(1, `REG_PWR_IDX, 2);
        idle(4);
        chkEv(5, 2);
        apb(1, `REG_PWR_IDX, 0);
        idle(4);
        chkEv(6, 2);
        conclude();
    end
endmodule
